/* hw/rspc_defines.vh */
// shared constants for the reset strap and port pin control block
// included by the pin control top and its per-port mux module
`ifndef RSPC_DEFINES_VH
`define RSPC_DEFINES_VH
// port a bit positions
`define RSPC_PA_TXD 0
`define RSPC_PA_RXD 1
`define RSPC_PA_EXTERNAL_IRQ_IN 2
`define RSPC_PA_GPIO_ONLY 3
`define RSPC_PA_AUTO_INCREMENT_N 4
`define RSPC_PA_HOLD 5
`define RSPC_PA_STRAP 6
`define RSPC_PA_CLOCK_OUTPUT 7
// bus control port bit carrying the test-mode-zero strap
`define RSPC_BC_TEST_MODE_ZERO_STRAP_N 4
// strap output value loaded while in reset (pins pulled high)
`define RSPC_STRAP_RESET 1'b1
// nonmaskable interrupt least high time in ns, one state time
`define RSPC_NMI_MIN_NS 100
`define RSPC_CLK_NS 100
`define RSPC_NMI_MIN_CYC ((`RSPC_NMI_MIN_NS + `RSPC_CLK_NS - 1) / `RSPC_CLK_NS)
`endif

/* hw/rspc_port_mux.v */
// one 8-bit port: per-bit choice between general i/o and a special function
// assumes the caller resolves bus overrides on its inputs; isolation is applied here
`include "rspc_defines.vh"
module rspc_port_mux (
  input wire [7:0] gpio_out,
  input wire [7:0] gpio_oe,
  input wire [7:0] sf_sel,
  input wire [7:0] sf_out,
  input wire [7:0] sf_oe,
  input wire open_drain,
  input wire force_push_pull,
  input wire isolate,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe
);
  integer i;
  // per-bit selection, then drive mode, then isolation override
  always @*
  begin
    pin_out = 8'h00;
    pin_oe = 8'h00;
    for (i = 0; i < 8; i = i + 1)
    begin
      if (sf_sel[i])
      begin
        pin_out[i] = sf_out[i];
        pin_oe[i] = sf_oe[i];
      end
      else
      begin
        pin_out[i] = gpio_out[i];
        pin_oe[i] = gpio_oe[i];
        // open drain only pulls low; the pull-up makes the one
        if (open_drain && !force_push_pull && gpio_out[i])
          pin_oe[i] = 1'b0;
      end
      if (isolate)
        pin_oe[i] = 1'b0;
    end
  end
endmodule

/* hw/rspc_pin_ctrl.v */
// pin control: nmi edge detect, reset straps, four port multiplexers
// assumes sys_clk at 10 MHz, board pulls straps as recommended
`include "rspc_defines.vh"
module rspc_pin_ctrl (
  input wire sys_clk,
  input wire resetn,
  // nonmaskable interrupt pin and arbitration
  input wire nmi_pin,
  input wire [7:0] other_irq_pending,
  output reg nmi_request,
  output reg [3:0] irq_grant_id,
  output reg irq_grant_valid,
  input wire nmi_ack,
  // mode indications
  output reg pin_isolation_mode,
  output reg reserved_test_mode,
  output reg test_mode_one_strap_n,
  input wire bus_hold_enable_bit,
  // port a
  input wire [7:0] port_a_in,
  output wire [7:0] port_a_out,
  output wire [7:0] port_a_oe,
  output reg [7:0] port_a_rd,
  input wire [7:0] port_a_gpio_out,
  input wire [7:0] port_a_gpio_oe,
  input wire [7:0] port_a_sf_sel,
  input wire serial_txd,
  output reg serial_rxd,
  output reg external_irq_in,
  input wire auto_increment_n,
  output reg bus_hold_req_n,
  input wire clock_output,
  input wire verify_status_out,
  input wire verify_status_en,
  // low and high bus ports
  input wire [7:0] low_bus_port_in,
  output wire [7:0] low_bus_port_out,
  output wire [7:0] low_bus_port_oe,
  input wire [7:0] high_bus_port_in,
  output wire [7:0] high_bus_port_out,
  output wire [7:0] high_bus_port_oe,
  input wire [7:0] low_bus_gpio_out,
  input wire [7:0] low_bus_gpio_oe,
  input wire [7:0] high_bus_gpio_out,
  input wire [7:0] high_bus_gpio_oe,
  input wire low_bus_open_drain,
  input wire high_bus_open_drain,
  input wire addr_data_sel,
  input wire prog_bus_sel,
  input wire [7:0] addr_data_low,
  input wire [7:0] addr_data_high,
  input wire addr_data_oe,
  input wire [7:0] prog_bus_low,
  input wire [7:0] prog_bus_high,
  input wire prog_bus_oe,
  output reg [15:0] bus_rd,
  // bus control port
  input wire [7:0] bus_control_port_in,
  output wire [7:0] bus_control_port_out,
  output wire [7:0] bus_control_port_oe,
  output reg [7:0] bus_control_rd,
  input wire [7:0] bus_control_gpio_out,
  input wire [7:0] bus_control_gpio_oe,
  input wire [7:0] bus_control_sf_sel,
  input wire [7:0] bus_control_sf_out,
  input wire [7:0] bus_control_sf_oe
);
  // two-stage synchronisers for every pin read
  reg [7:0] pa_s1, pa_s2, lb_s1, lb_s2, hb_s1, hb_s2, bc_s1, bc_s2;
  reg nmi_s1, nmi_s2, nmi_prev;
  // one-shot marker: straps are taken on the first edge after release
  reg straps_taken;
  // latched hold selection, frozen while bus hold is enabled
  reg hold_sel;
  integer k;

  // synchronise all pins
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pa_s1 <= 8'hff;
      pa_s2 <= 8'hff;
      lb_s1 <= 8'h00;
      lb_s2 <= 8'h00;
      hb_s1 <= 8'h00;
      hb_s2 <= 8'h00;
      bc_s1 <= 8'hff;
      bc_s2 <= 8'hff;
      nmi_s1 <= 1'b0;
      nmi_s2 <= 1'b0;
    end
    else
    begin
      pa_s1 <= port_a_in;
      pa_s2 <= pa_s1;
      lb_s1 <= low_bus_port_in;
      lb_s2 <= lb_s1;
      hb_s1 <= high_bus_port_in;
      hb_s2 <= hb_s1;
      bc_s1 <= bus_control_port_in;
      bc_s2 <= bc_s1;
      nmi_s1 <= nmi_pin;
      nmi_s2 <= nmi_s1;
    end
  end

  // nmi edge detect; request stays until acknowledged, set beats clear
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      nmi_prev <= 1'b0;
      nmi_request <= 1'b0;
    end
    else
    begin
      nmi_prev <= nmi_s2;
      if (nmi_s2 && !nmi_prev)
        nmi_request <= 1'b1;
      else if (nmi_ack)
        nmi_request <= 1'b0;
    end
  end
  // a pulse of one state time (one cycle here) survives the
  // synchroniser only if held past a sampling edge, hence the
  // board must hold it longer than RSPC_NMI_MIN_CYC cycles.

  // priority arbiter: nmi first, then lowest numbered source
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      irq_grant_id <= 4'h0;
      irq_grant_valid <= 1'b0;
    end
    else
    begin
      irq_grant_valid <= nmi_request || (|other_irq_pending);
      irq_grant_id <= 4'h0;
      if (nmi_request)
        irq_grant_id <= 4'h8;
      else
      begin
        for (k = 7; k >= 0; k = k - 1)
          if (other_irq_pending[k])
            irq_grant_id <= k[3:0];
      end
    end
  end

  // strap synchroniser, deliberately without reset: it keeps tracking
  // the two strap pins while resetn is low, so its second stage holds
  // the level seen just before release when the capture below fires.
  // limitation: resetn must stay low for at least two clock edges.
  reg [1:0] strap_s1;
  reg [1:0] strap_s2;
  always @(posedge sys_clk)
  begin
    strap_s1 <= {bus_control_port_in[`RSPC_BC_TEST_MODE_ZERO_STRAP_N],
      port_a_in[`RSPC_PA_STRAP]};
    strap_s2 <= strap_s1;
  end

  // strap capture on the first edge after release, from the second
  // synchroniser stage; the reset-loaded port stages would only show
  // their constant there, so they cannot serve as the source.
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      straps_taken <= 1'b0;
      pin_isolation_mode <= 1'b0;
      reserved_test_mode <= 1'b0;
      test_mode_one_strap_n <= `RSPC_STRAP_RESET;
    end
    else if (!straps_taken)
    begin
      straps_taken <= 1'b1;
      pin_isolation_mode <= !strap_s2[0];
      // same pin also reads as test strap one
      test_mode_one_strap_n <= strap_s2[0];
      // test strap zero on same edge
      reserved_test_mode <= !strap_s2[1];
    end
  end

  // bus hold selection is only reconfigurable while hold is disabled
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      hold_sel <= 1'b0;
    else if (!bus_hold_enable_bit)
      hold_sel <= port_a_sf_sel[`RSPC_PA_HOLD];
  end

  // registered readback of inputs to the core
  always @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      port_a_rd <= 8'h00;
      serial_rxd <= 1'b1;
      external_irq_in <= 1'b0;
      bus_hold_req_n <= 1'b1;
      bus_rd <= 16'h0000;
      bus_control_rd <= 8'h00;
    end
    else
    begin
      port_a_rd <= pa_s2;
      serial_rxd <= port_a_sf_sel[`RSPC_PA_RXD] ? pa_s2[`RSPC_PA_RXD] : 1'b1;
      external_irq_in <= port_a_sf_sel[`RSPC_PA_EXTERNAL_IRQ_IN] &&
        pa_s2[`RSPC_PA_EXTERNAL_IRQ_IN];
      bus_hold_req_n <= (bus_hold_enable_bit || hold_sel) ?
        pa_s2[`RSPC_PA_HOLD] : 1'b1;
      bus_rd <= {hb_s2, lb_s2};
      bus_control_rd <= bc_s2;
    end
  end

  // port a special function selection and values
  reg [7:0] pa_sf_sel;
  reg [7:0] pa_sf_out;
  reg [7:0] pa_sf_oe;
  reg [7:0] pa_gpio_oe;
  always @*
  begin
    pa_sf_sel = port_a_sf_sel;
    pa_sf_out = 8'h00;
    pa_sf_oe = 8'h00;
    pa_gpio_oe = port_a_gpio_oe;
    pa_sf_out[`RSPC_PA_TXD] = serial_txd;
    pa_sf_oe[`RSPC_PA_TXD] = 1'b1;
    pa_sf_out[`RSPC_PA_AUTO_INCREMENT_N] = auto_increment_n;
    pa_sf_oe[`RSPC_PA_AUTO_INCREMENT_N] = 1'b1;
    pa_sf_out[`RSPC_PA_CLOCK_OUTPUT] = clock_output;
    pa_sf_oe[`RSPC_PA_CLOCK_OUTPUT] = 1'b1;
    // verify status output on strap pin
    pa_sf_out[`RSPC_PA_STRAP] = verify_status_out;
    pa_sf_oe[`RSPC_PA_STRAP] = verify_status_en;
    pa_sf_sel[`RSPC_PA_GPIO_ONLY] = 1'b0;
    if (bus_hold_enable_bit)
    begin
      pa_sf_sel[`RSPC_PA_HOLD] = 1'b1;
      pa_gpio_oe[`RSPC_PA_HOLD] = 1'b0;
    end
    else
      pa_sf_sel[`RSPC_PA_HOLD] = hold_sel;
  end

  // bus port sources: address/data has priority over the program bus
  wire bus_sf = addr_data_sel || prog_bus_sel;
  wire [7:0] low_sf_out = addr_data_sel ? addr_data_low : prog_bus_low;
  wire [7:0] high_sf_out = addr_data_sel ? addr_data_high : prog_bus_high;
  wire bus_sf_oe = addr_data_sel ? addr_data_oe : prog_bus_oe;

  rspc_port_mux u_port_a (
    .gpio_out(port_a_gpio_out),
    .gpio_oe(pa_gpio_oe),
    .sf_sel(pa_sf_sel),
    .sf_out(pa_sf_out),
    .sf_oe(pa_sf_oe),
    .open_drain(1'b0),
    .force_push_pull(1'b0),
    .isolate(pin_isolation_mode),
    .pin_out(port_a_out),
    .pin_oe(port_a_oe)
  );

  rspc_port_mux u_low_bus (
    .gpio_out(low_bus_gpio_out),
    .gpio_oe(low_bus_gpio_oe),
    .sf_sel({8{bus_sf}}),
    .sf_out(low_sf_out),
    .sf_oe({8{bus_sf_oe}}),
    .open_drain(low_bus_open_drain),
    .force_push_pull(addr_data_sel),
    .isolate(pin_isolation_mode),
    .pin_out(low_bus_port_out),
    .pin_oe(low_bus_port_oe)
  );

  rspc_port_mux u_high_bus (
    .gpio_out(high_bus_gpio_out),
    .gpio_oe(high_bus_gpio_oe),
    .sf_sel({8{bus_sf}}),
    .sf_out(high_sf_out),
    .sf_oe({8{bus_sf_oe}}),
    .open_drain(high_bus_open_drain),
    .force_push_pull(addr_data_sel),
    .isolate(pin_isolation_mode),
    .pin_out(high_bus_port_out),
    .pin_oe(high_bus_port_oe)
  );

  rspc_port_mux u_bus_ctrl (
    .gpio_out(bus_control_gpio_out),
    .gpio_oe(bus_control_gpio_oe),
    .sf_sel(bus_control_sf_sel),
    .sf_out(bus_control_sf_out),
    .sf_oe(bus_control_sf_oe),
    .open_drain(1'b0),
    .force_push_pull(1'b0),
    .isolate(pin_isolation_mode),
    .pin_out(bus_control_port_out),
    .pin_oe(bus_control_port_oe)
  );
endmodule

/* bench/rspc_pin_ctrl_assertions.sv */
// concurrent checks on the pin control block, top-level ports only
// assumes one sys_clk domain and an asynchronous active-low resetn
module rspc_pin_ctrl_assertions (
  input wire sys_clk,
  input wire resetn,
  input wire nmi_pin,
  input wire nmi_request,
  input wire [3:0] irq_grant_id,
  input wire irq_grant_valid,
  input wire pin_isolation_mode,
  input wire reserved_test_mode,
  input wire bus_hold_enable_bit,
  input wire [7:0] port_a_oe,
  input wire [7:0] port_a_gpio_oe,
  input wire [7:0] low_bus_port_oe,
  input wire [7:0] low_bus_port_out,
  input wire [7:0] high_bus_port_oe,
  input wire [7:0] high_bus_port_out,
  input wire [7:0] bus_control_port_oe,
  input wire addr_data_sel,
  input wire addr_data_oe,
  input wire [7:0] addr_data_low,
  input wire [7:0] addr_data_high
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  // two sync stages then the request register
  nmi_edge_a: assert property ($rose(nmi_pin) |-> ##3 nmi_request)
    else $error("nmi request late or missing");
  nmi_prio_a: assert property (nmi_request |=>
    irq_grant_valid && irq_grant_id == 4'h8)
    else $error("nmi did not win arbitration");
  iso_float_a: assert property (pin_isolation_mode |->
    (port_a_oe | low_bus_port_oe | high_bus_port_oe |
     bus_control_port_oe) == 8'h00)
    else $error("pin driven while isolated");
  // straps settle on the first edge after release, then hold
  strap_hold_a: assert property ($past(resetn, 2) |->
    $stable(pin_isolation_mode) && $stable(reserved_test_mode))
    else $error("strap mode changed without reset");
  gpio_only_a: assert property (!pin_isolation_mode |->
    port_a_oe[3] == port_a_gpio_oe[3])
    else $error("port a bit 3 left general i/o");
  ad_low_a: assert property (addr_data_sel && !pin_isolation_mode |->
    low_bus_port_oe == {8{addr_data_oe}} &&
    low_bus_port_out == addr_data_low)
    else $error("low bus port not carrying address/data");
  ad_high_a: assert property (addr_data_sel && !pin_isolation_mode |->
    high_bus_port_oe == {8{addr_data_oe}} &&
    high_bus_port_out == addr_data_high)
    else $error("high bus port not carrying address/data");
  hold_pin_a: assert property (bus_hold_enable_bit |-> !port_a_oe[5])
    else $error("hold pin driven while hold enabled");
endmodule

/* bench/rspc_board.sv */
// board model: pull-ups on every port pin, strap levels on two of them
// assumes the device drives a pin only while its oe bit is high
module rspc_board (
  input wire [7:0] port_a_out,
  input wire [7:0] port_a_oe,
  input wire [7:0] low_bus_port_out,
  input wire [7:0] low_bus_port_oe,
  input wire [7:0] high_bus_port_out,
  input wire [7:0] high_bus_port_oe,
  input wire [7:0] bus_control_port_out,
  input wire [7:0] bus_control_port_oe,
  input wire iso_strap_n,
  input wire tm0_strap_n,
  output wire [7:0] port_a_in,
  output wire [7:0] low_bus_port_in,
  output wire [7:0] high_bus_port_in,
  output wire [7:0] bus_control_port_in
);
  timeunit 1ns;
  timeprecision 1ns;
  assign port_a_in = (port_a_oe & port_a_out) |
    (~port_a_oe & {1'b1, iso_strap_n, 6'h3f});
  assign bus_control_port_in = (bus_control_port_oe & bus_control_port_out) |
    (~bus_control_port_oe & {3'h7, tm0_strap_n, 4'hf});
  // released bus pins rise to the pull-up, so open drain reads back ones
  assign low_bus_port_in = (low_bus_port_oe & low_bus_port_out) |
    ~low_bus_port_oe;
  assign high_bus_port_in = (high_bus_port_oe & high_bus_port_out) |
    ~high_bus_port_oe;
endmodule

/* bench/tb.sv */
// directed bench for the pin control block with a pull-up board model
// assumes the checker binds to the design top by port name
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, resetn = 0, nmi_pin = 0, nmi_ack = 0;
  logic bus_hold_enable_bit = 0, addr_data_sel = 0, prog_bus_sel = 0;
  logic addr_data_oe = 0, prog_bus_oe = 0, serial_txd = 0;
  logic low_bus_open_drain = 0, high_bus_open_drain = 0;
  logic auto_increment_n = 1, clock_output = 0;
  logic verify_status_out = 0, verify_status_en = 0;
  logic iso_strap_n = 1, tm0_strap_n = 1;
  logic [7:0] other_irq_pending = '0, port_a_gpio_out = '0;
  logic [7:0] port_a_gpio_oe = '0, port_a_sf_sel = '0;
  logic [7:0] low_bus_gpio_out = '0, low_bus_gpio_oe = '0;
  logic [7:0] high_bus_gpio_out = '0, high_bus_gpio_oe = '0;
  logic [7:0] addr_data_low = '0, addr_data_high = '0;
  logic [7:0] prog_bus_low = '0, prog_bus_high = '0;
  logic [7:0] bus_control_gpio_out = '0, bus_control_gpio_oe = '0;
  logic [7:0] bus_control_sf_sel = '0, bus_control_sf_out = '0;
  logic [7:0] bus_control_sf_oe = '0;
  wire nmi_request, irq_grant_valid, pin_isolation_mode, reserved_test_mode;
  wire test_mode_one_strap_n, serial_rxd, external_irq_in, bus_hold_req_n;
  wire [3:0] irq_grant_id;
  wire [15:0] bus_rd;
  wire [7:0] port_a_in, port_a_out, port_a_oe, port_a_rd;
  wire [7:0] low_bus_port_in, low_bus_port_out, low_bus_port_oe;
  wire [7:0] high_bus_port_in, high_bus_port_out, high_bus_port_oe;
  wire [7:0] bus_control_port_in, bus_control_port_out;
  wire [7:0] bus_control_port_oe, bus_control_rd;
  int n_errors = 0, n_checks = 0;

  rspc_pin_ctrl uut (.*);
  rspc_board board (.*);

  // 10 MHz state clock
  always #50 sys_clk = ~sys_clk;

  task automatic chk(input bit ok, input string msg);
    n_checks++;
    if (!ok)
    begin
      n_errors++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // nmi held five cycles, beating a pending source, then acknowledged
  task automatic t_nmi;
    @(posedge sys_clk);
    other_irq_pending <= 8'h04;
    nmi_pin <= 1;
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(nmi_request === 1'b1, "nmi request");
    @(negedge sys_clk);
    chk(irq_grant_id === 4'h8 && irq_grant_valid === 1'b1, "nmi grant");
    @(posedge sys_clk);
    nmi_pin <= 0;
    nmi_ack <= 1;
    @(posedge sys_clk);
    nmi_ack <= 0;
    @(negedge sys_clk);
    chk(nmi_request === 1'b0, "nmi ack");
    @(negedge sys_clk);
    chk(irq_grant_id === 4'h2 && irq_grant_valid === 1'b1, "low grant");
  endtask

  // every bit on special function; bit 3 stays gpio, bit 5 held by hold
  task automatic t_ports;
    @(posedge sys_clk);
    port_a_sf_sel <= 8'hff;
    port_a_gpio_oe <= 8'h28;
    port_a_gpio_out <= 8'h08;
    serial_txd <= 1;
    bus_hold_enable_bit <= 1;
    bus_control_sf_sel <= 8'h0f;
    bus_control_sf_out <= 8'h05;
    bus_control_sf_oe <= 8'h0f;
    bus_control_gpio_out <= 8'he0;
    bus_control_gpio_oe <= 8'he0;
    repeat (4) @(negedge sys_clk);
    chk(port_a_out[3] === 1'b1 && port_a_oe[3] === 1'b1, "bit 3");
    chk(port_a_out[0] === 1'b1 && port_a_oe[0] === 1'b1, "txd");
    chk(port_a_oe[5] === 1'b0, "hold pin");
    chk(port_a_rd === 8'h7f, "port a read");
    chk(serial_rxd === 1'b1 && external_irq_in === 1'b1, "rx/external_irq_in");
    chk(bus_hold_req_n === 1'b1, "hold input");
    chk(bus_control_rd === 8'hf5, "bc read");
    chk(bus_control_port_out[3:0] === 4'h5, "bc special");
    chk(bus_control_port_oe === 8'hef, "bc enables");
    @(posedge sys_clk);
    bus_hold_enable_bit <= 0;
  endtask

  // open drain gpio, then address/data and program bus overrides
  task automatic t_bus;
    @(posedge sys_clk);
    low_bus_open_drain <= 1;
    low_bus_gpio_out <= 8'h5a;
    low_bus_gpio_oe <= 8'hff;
    high_bus_gpio_oe <= 8'hff;
    high_bus_gpio_out <= 8'h81;
    repeat (4) @(negedge sys_clk);
    chk(low_bus_port_oe === 8'ha5, "open drain");
    chk(bus_rd === 16'h815a, "bus read");
    @(posedge sys_clk);
    addr_data_sel <= 1;
    addr_data_oe <= 1;
    addr_data_low <= 8'h3c;
    addr_data_high <= 8'hc3;
    repeat (4) @(negedge sys_clk);
    chk(low_bus_port_oe === 8'hff, "push pull");
    chk(bus_rd === 16'hc33c, "address/data");
    @(posedge sys_clk);
    addr_data_sel <= 0;
    prog_bus_sel <= 1;
    prog_bus_oe <= 1;
    prog_bus_low <= 8'h69;
    prog_bus_high <= 8'h96;
    @(negedge sys_clk);
    chk(low_bus_port_out === 8'h69, "prog bus low");
    chk(high_bus_port_out === 8'h96, "prog bus high");
  endtask

  // reset with given straps, then drop them and look at the modes
  task automatic t_strap(input logic iso_n, input logic tm0_n);
    @(posedge sys_clk);
    resetn <= 0;
    port_a_gpio_oe <= 8'hbf;
    bus_control_gpio_oe <= 8'hef;
    iso_strap_n <= iso_n;
    tm0_strap_n <= tm0_n;
    repeat (3) @(posedge sys_clk);
    resetn <= 1;
    repeat (2) @(posedge sys_clk);
    iso_strap_n <= 1;
    tm0_strap_n <= 1;
    repeat (2) @(negedge sys_clk);
    chk(pin_isolation_mode === !iso_n, "isolation");
    chk(reserved_test_mode === !tm0_n, "test mode");
    chk(test_mode_one_strap_n === iso_n, "shared strap");
    chk(iso_n || (port_a_oe | low_bus_port_oe | high_bus_port_oe |
      bus_control_port_oe) === 8'h00, "float");
  endtask

  initial
  begin
    repeat (8) @(posedge sys_clk);
    resetn <= 1;
    repeat (2) @(posedge sys_clk);
    t_nmi;
    t_ports;
    t_bus;
    t_strap(1'b0, 1'b1);
    t_strap(1'b1, 1'b0);
    t_strap(1'b1, 1'b1);
    conclude;
  end

  // run needs about 55 cycles; cut a hang at 2000
  initial
  begin
    #200000;
    n_errors++;
    conclude;
  end
endmodule

bind rspc_pin_ctrl rspc_pin_ctrl_assertions chk_i (.*);
